// ### design/rx_irq_pkg.sv
// Register map, field positions and constants for the receive interrupt enable block
package rx_irq_pkg;
  localparam logic [7:0] ELASTIC_TIMER_EN_OFS = 8'ha3;
  localparam logic [7:0] HDLC_EN_OFS = 8'ha4;
  localparam logic [7:0] BOC_FDL_EN_OFS = 8'ha6;
  localparam logic [7:0] SIG_CH1_8_OFS = 8'ha8;
  localparam logic [7:0] SIG_CH9_16_OFS = 8'ha9;
  localparam logic [7:0] SIG_CH17_24_OFS = 8'haa;
  localparam logic [7:0] SIG_CH25_32_OFS = 8'hab;
  localparam logic [7:0] LOOP_UP_LO_OFS = 8'hac;
  localparam logic [7:0] LOOP_UP_HI_OFS = 8'had;
  localparam logic [7:0] LOOP_DOWN_LO_OFS = 8'hae;
  localparam logic [7:0] CONTROL_OFS = 8'hc0;
  localparam logic [7:0] STATUS_OFS = 8'hc1;
  localparam logic [7:0] LATCHED_OFS = 8'hc2;
  localparam logic [7:0] SUMMARY_OFS = 8'hc3;
  localparam logic [7:0] ELASTIC_TIMER_VALID = 8'hef;
  localparam logic [7:0] HDLC_VALID = 8'h3f;
  localparam logic [7:0] BOC_FDL_T1_VALID = 8'h3f;
  localparam logic [7:0] SA_E1_VALID = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SIG_CHANGE_BIT = 3;
  localparam int CTRL_E1_BIT = 0;
  localparam int CTRL_LEN_LSB = 1;
  localparam int SUM_ELASTIC_BIT = 3;
  localparam int SUM_HDLC_BIT = 4;
  localparam int SUM_BOC_BIT = 6;
  localparam int CHANNELS = 32;
  localparam int T1_CHANNELS = 24;
  localparam int CODE_LEN_W = 4;
  localparam logic [3:0] CODE_LEN_RESET = 4'h5;
  localparam int INTEGRATION_CYCLES = 48;
endpackage

// ### design/loop_code_detector.sv
// Repeating loop-up pattern detector with restartable integration period
`timescale 1ns/10ps
module loop_code_detector
  import rx_irq_pkg::*;
#(
  parameter int INTEGRATE = INTEGRATION_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic enable_i,
  input wire logic restart_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  input wire logic [3:0] code_len_i,
  input wire logic [15:0] pattern_i,
  output logic loop_up_seen_o
);
  logic [15:0] history;
  logic [15:0] cmp_mask;
  logic [15:0] expected;
  logic [15:0] match_run;
  logic [4:0] len;
  logic [3:0] lag;
  logic [15:0] recent;
  logic hit;
  logic steady;

  always_comb begin
    len = (code_len_i == 4'h0) ? 5'd16 : {1'b0, code_len_i};
    lag = 4'(len - 5'd1);
    cmp_mask = 16'hffff << (5'd16 - len);
    // The newest L bits sit under the pattern, the oldest of them against bit 15
    recent = history << (5'd16 - len);
    // Pattern bit 15 (first register bit 7) leads; lengths up to 8 never reach the second register
    expected = pattern_i & cmp_mask;
    hit = ((recent & cmp_mask) == expected);
    // Once aligned, a stream that repeats every L bits stays in step in every phase
    steady = (bit_i == history[lag]);
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      history <= 16'h0000;
    end else if (bit_valid_i) begin
      history <= {history[14:0], bit_i};
    end
  end

  // Any code write or leaving T1 starts integration afresh
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      match_run <= 16'h0000;
    end else if (restart_i || !enable_i) begin
      match_run <= 16'h0000;
    end else if (bit_valid_i) begin
      if ((match_run == 16'h0000) ? !hit : !steady) begin
        match_run <= 16'h0000;
      end else if (match_run != 16'hffff) begin
        match_run <= match_run + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_up_seen_o <= 1'b0;
    end else begin
      loop_up_seen_o <= enable_i && !restart_i && (match_run >= 16'(INTEGRATE));
    end
  end
endmodule

// ### design/rx_irq_mask_and_loop_code_regs.sv
// Receive interrupt enables, signaling change enables and loop-up code registers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module rx_irq_mask_and_loop_code_regs
  import rx_irq_pkg::*;
#(
  parameter int INTEGRATE = INTEGRATION_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] elastic_timer_event_i,
  input wire logic [5:0] hdlc_event_i,
  input wire logic [5:0] boc_fdl_event_i,
  input wire logic sa_six_codeword_i,
  input wire logic [7:0] sa_bit_change_i,
  input wire logic [7:0] sa_bit_position_mask_i,
  input wire logic [CHANNELS-1:0] sig_change_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_i,
  output logic [7:0] rx_irq_source_summary_o,
  output logic loop_up_seen_o,
  output logic irq_request_o
);
  logic [7:0] rx_elastic_timer_irq_enable;
  logic [7:0] rx_hdlc_irq_enable;
  logic [7:0] rx_boc_fdl_irq_enable;
  logic [7:0] sig_change_enable [4];
  logic [7:0] loop_up_pattern_lo;
  logic [7:0] loop_up_pattern_hi;
  logic [7:0] loop_down_pattern_lo;
  logic e1_mode;
  logic [3:0] code_len;
  logic [7:0] rx_latched_status_four;
  logic [7:0] hdlc_latched;
  logic [7:0] boc_latched;
  logic [7:0] boc_events;
  logic [7:0] elastic_events;
  logic [CHANNELS-1:0] ch_enabled;
  logic [CHANNELS-1:0] ch_allowed;
  logic [7:0] next_summary;
  logic [7:0] wbyte;
  logic [7:0] addr8;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic code_write;
  logic loop_up_raw;
  logic loop_up_prev;
  logic [31:0] next_rdata;
  logic rd_latched;
  logic rd_status;

  assign addr8 = paddr_i[9:2];
  assign wbyte = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o && mapped && pstrb_i[0];
  assign rd_en = psel_i && penable_i && !pwrite_i && pready_o;

  // A read clears only the flags it returned; one that lands after the data was taken survives
  assign rd_latched = rd_en && (addr8 == LATCHED_OFS);
  assign rd_status = rd_en && (addr8 == STATUS_OFS);

  // Upper address bits must be zero; only the listed words answer without error
  always_comb begin
    case (addr8)
      ELASTIC_TIMER_EN_OFS, HDLC_EN_OFS, BOC_FDL_EN_OFS, SIG_CH1_8_OFS, SIG_CH9_16_OFS,
      SIG_CH17_24_OFS, SIG_CH25_32_OFS, LOOP_UP_LO_OFS, LOOP_UP_HI_OFS, LOOP_DOWN_LO_OFS,
      CONTROL_OFS, STATUS_OFS, LATCHED_OFS, SUMMARY_OFS: mapped = (paddr_i[11:10] == 2'b00);
      default: mapped = 1'b0;
    endcase
  end

  // Any pattern write, loop-down included, starts the loop-up integration over
  assign code_write = wr_en && (addr8 == LOOP_UP_LO_OFS || addr8 == LOOP_UP_HI_OFS
                      || addr8 == LOOP_DOWN_LO_OFS);

  // One-wait-state slave: pready is high in the second access cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
    end
  end

  // Unmapped words answer with an error in the same cycle as pready, the second access cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
    end
  end

  // Each enable register is its own flop group; only its word address loads it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_elastic_timer_irq_enable <= REG_RESET;
    end else if (wr_en && addr8 == ELASTIC_TIMER_EN_OFS) begin
      rx_elastic_timer_irq_enable <= wbyte & ELASTIC_TIMER_VALID;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_hdlc_irq_enable <= REG_RESET;
    end else if (wr_en && addr8 == HDLC_EN_OFS) begin
      rx_hdlc_irq_enable <= wbyte & HDLC_VALID;
    end
  end

  // One word serves both line modes; the summary picks the bits that mean something
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_boc_fdl_irq_enable <= REG_RESET;
    end else if (wr_en && addr8 == BOC_FDL_EN_OFS) begin
      rx_boc_fdl_irq_enable <= wbyte & BOC_FDL_T1_VALID;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_up_pattern_lo <= REG_RESET;
    end else if (wr_en && addr8 == LOOP_UP_LO_OFS) begin
      loop_up_pattern_lo <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_up_pattern_hi <= REG_RESET;
    end else if (wr_en && addr8 == LOOP_UP_HI_OFS) begin
      loop_up_pattern_hi <= wbyte;
    end
  end

  // Loop-down pattern is kept for software only; no detector reads it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_down_pattern_lo <= REG_RESET;
    end else if (wr_en && addr8 == LOOP_DOWN_LO_OFS) begin
      loop_down_pattern_lo <= wbyte;
    end
  end

  // Leaving T1 also holds the loop-up detector idle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      e1_mode <= 1'b0;
    end else if (wr_en && addr8 == CONTROL_OFS) begin
      e1_mode <= wbyte[CTRL_E1_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_len <= CODE_LEN_RESET;
    end else if (wr_en && addr8 == CONTROL_OFS) begin
      code_len <= wbyte[CTRL_LEN_LSB +: CODE_LEN_W];
    end
  end

  // One byte per eight channels, lowest channel in bit 0
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sig_en
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sig_change_enable[g] <= REG_RESET;
        end else if (wr_en && addr8 == SIG_CH1_8_OFS + 8'(g)) begin
          sig_change_enable[g] <= wbyte;
        end
      end
      assign ch_enabled[g*8 +: 8] = sig_change_enable[g];
    end
  endgenerate

  // Channels 25..32 exist only on an E1 line
  assign ch_allowed = e1_mode ? ch_enabled : {8'h00, ch_enabled[T1_CHANNELS-1:0]};

  // Sa change counts only positions whose mask bit is clear
  always_comb begin
    boc_events = {2'b00, boc_fdl_event_i};
    if (e1_mode) begin
      boc_events = {6'h00, sa_six_codeword_i, |(sa_bit_change_i & ~sa_bit_position_mask_i)};
    end
  end

  always_comb begin
    elastic_events = elastic_timer_event_i & ELASTIC_TIMER_VALID;
    elastic_events[SIG_CHANGE_BIT] = elastic_timer_event_i[SIG_CHANGE_BIT]
                                     | (|(sig_change_i & ch_allowed));
  end

  // Flags latch regardless of interrupt enables (a channel's signaling change needs its channel enable); an event in the clearing cycle wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_latched_status_four <= REG_RESET;
    end else if (rd_latched) begin
      rx_latched_status_four <= (rx_latched_status_four & ~prdata_o[7:0]) | elastic_events;
    end else begin
      rx_latched_status_four <= rx_latched_status_four | elastic_events;
    end
  end

  // HDLC and BOC flags share one status word and clear together
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hdlc_latched <= REG_RESET;
    end else if (rd_status) begin
      hdlc_latched <= (hdlc_latched & ~prdata_o[7:0]) | {2'b00, hdlc_event_i};
    end else begin
      hdlc_latched <= hdlc_latched | {2'b00, hdlc_event_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boc_latched <= REG_RESET;
    end else if (rd_status) begin
      boc_latched <= (boc_latched & ~prdata_o[15:8]) | boc_events;
    end else begin
      boc_latched <= boc_latched | boc_events;
    end
  end

  loop_code_detector #(
    .INTEGRATE(INTEGRATE)
  ) u_loop_up (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .enable_i(!e1_mode),
    .restart_i(code_write),
    .bit_valid_i(rx_bit_valid_i),
    .bit_i(rx_bit_i),
    .code_len_i(code_len),
    .pattern_i({loop_up_pattern_lo, loop_up_pattern_hi}),
    .loop_up_seen_o(loop_up_raw)
  );

  // Registered again so the pin comes from a flop of this module
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_up_seen_o <= 1'b0;
    end else begin
      loop_up_seen_o <= loop_up_raw;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_up_prev <= 1'b0;
    end else begin
      loop_up_prev <= loop_up_raw;
    end
  end

  // Only enabled flags reach the summary and the request line
  always_comb begin
    next_summary = 8'h00;
    next_summary[SUM_ELASTIC_BIT] = |(rx_latched_status_four & rx_elastic_timer_irq_enable);
    next_summary[SUM_HDLC_BIT] = |(hdlc_latched & rx_hdlc_irq_enable);
    if (e1_mode) begin
      next_summary[SUM_BOC_BIT] = |(boc_latched & rx_boc_fdl_irq_enable & SA_E1_VALID);
    end else begin
      next_summary[SUM_BOC_BIT] = |(boc_latched & rx_boc_fdl_irq_enable & BOC_FDL_T1_VALID);
    end
  end

  // Registered so the summary and the request never glitch while flags settle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_irq_source_summary_o <= 8'h00;
    end else begin
      rx_irq_source_summary_o <= next_summary;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_request_o <= 1'b0;
    end else begin
      irq_request_o <= |next_summary;
    end
  end

  // Unused upper lanes read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (addr8)
      ELASTIC_TIMER_EN_OFS: next_rdata[7:0] = rx_elastic_timer_irq_enable;
      HDLC_EN_OFS: next_rdata[7:0] = rx_hdlc_irq_enable;
      BOC_FDL_EN_OFS: next_rdata[7:0] = rx_boc_fdl_irq_enable;
      SIG_CH1_8_OFS: next_rdata[7:0] = sig_change_enable[0];
      SIG_CH9_16_OFS: next_rdata[7:0] = sig_change_enable[1];
      SIG_CH17_24_OFS: next_rdata[7:0] = sig_change_enable[2];
      SIG_CH25_32_OFS: next_rdata[7:0] = sig_change_enable[3];
      LOOP_UP_LO_OFS: next_rdata[7:0] = loop_up_pattern_lo;
      LOOP_UP_HI_OFS: next_rdata[7:0] = loop_up_pattern_hi;
      LOOP_DOWN_LO_OFS: next_rdata[7:0] = loop_down_pattern_lo;
      CONTROL_OFS: next_rdata[7:0] = {loop_up_prev, 2'b00, code_len, e1_mode};
      STATUS_OFS: next_rdata[15:0] = {boc_latched, hdlc_latched};
      LATCHED_OFS: next_rdata[7:0] = rx_latched_status_four;
      SUMMARY_OFS: next_rdata[7:0] = rx_irq_source_summary_o;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Taken in the first access cycle and held through the ready edge, where flags clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_o && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end
endmodule

// ### sim/rx_irq_assertions.sv
// Port-level checks for the receive interrupt enable block
`timescale 1ns/10ps
module rx_irq_assertions
  import rx_irq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] elastic_timer_event_i,
  input wire logic [5:0] hdlc_event_i,
  input wire logic [5:0] boc_fdl_event_i,
  input wire logic sa_six_codeword_i,
  input wire logic [7:0] sa_bit_change_i,
  input wire logic [CHANNELS-1:0] sig_change_i,
  input wire logic [7:0] rx_irq_source_summary_o,
  input wire logic loop_up_seen_o,
  input wire logic irq_request_o
);
  logic acc;
  // A completed access may legally move the summary (mask write or clear on read)
  assign acc = psel_i && penable_i && pready_o;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  AST_IRQ_OR: assert property (irq_request_o == |rx_irq_source_summary_o)
    else $error("irq request disagrees with summary");
  AST_EL_RISE: assert property ($rose(rx_irq_source_summary_o[3]) |->
    $past(|elastic_timer_event_i, 2) || $past(|sig_change_i, 2) || $past(|sig_change_i, 3)
    || $past(acc) || $past(acc, 2)) else $error("elastic summary rose without cause");
  AST_HD_RISE: assert property ($rose(rx_irq_source_summary_o[4]) |->
    $past(|hdlc_event_i, 2) || $past(acc) || $past(acc, 2))
    else $error("hdlc summary rose without cause");
  AST_BOC_RISE: assert property ($rose(rx_irq_source_summary_o[6]) |->
    $past(|boc_fdl_event_i || sa_six_codeword_i || |sa_bit_change_i, 2)
    || $past(acc) || $past(acc, 2)) else $error("boc summary rose without cause");
  AST_HD_FALL: assert property ($fell(rx_irq_source_summary_o[4]) |->
    $past(acc) || $past(acc, 2)) else $error("hdlc summary fell without access");
  AST_WAIT: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  AST_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_LOOP: assert property ($rose(loop_up_seen_o) |->
    !$past(acc && pwrite_i) && !$past(acc && pwrite_i, 2))
    else $error("loop-up seen right after a write");
endmodule

bind rx_irq_mask_and_loop_code_regs rx_irq_assertions u_rx_irq_assertions (
  .sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o,
  .elastic_timer_event_i, .hdlc_event_i, .boc_fdl_event_i, .sa_six_codeword_i,
  .sa_bit_change_i, .sig_change_i, .rx_irq_source_summary_o, .loop_up_seen_o, .irq_request_o);

// ### sim/apb_host_model.sv
// APB host model issuing register reads and writes
`timescale 1ns/10ps
module apb_host_model (
  input wire logic sys_clk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic hung_o
);
  initial begin
    psel_o = 0;
    penable_o = 0;
    pwrite_o = 0;
    paddr_o = 0;
    pwdata_o = 0;
    pstrb_o = 4'h1;
    hung_o = 0;
  end
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [7:0] wd,
                      output logic [15:0] rd, output logic err);
    int n;
    n = 0;
    psel_o <= 1;
    pwrite_o <= wr;
    paddr_o <= {2'b00, ofs, 2'b00};
    pwdata_o <= {24'h0, wd};
    @(posedge sys_clk_i);
    penable_o <= 1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 16);
    if (pready_i !== 1'b1) hung_o <= 1;
    rd = prdata_i[15:0];
    err = pslverr_i;
    psel_o <= 0;
    penable_o <= 0;
    // Released data flips so a stale value is never mistaken for a fresh one
    pwdata_o <= ~pwdata_o;
    @(posedge sys_clk_i);
  endtask
endmodule

// ### sim/rx_irq_mask_and_loop_code_regs_tb_top.sv
// Self-checking bench for the receive interrupt enable and loop-up code block
`timescale 1ns/10ps
module rx_irq_mask_and_loop_code_regs_tb_top
  import rx_irq_pkg::*;
;
  logic sys_clk_i = 0;
  logic arst_n_i = 0;
  logic psel, penable, pwrite, pready, pslverr, hung, seen, irq, err;
  logic sa6 = 0;
  logic bit_v = 0;
  logic bit_d = 0;
  logic stream_on = 0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] el_ev = 0, sa_ch = 0, sa_msk = 0, summ;
  logic [5:0] hd_ev = 0, bf_ev = 0;
  logic [CHANNELS-1:0] sig = 0;
  logic [15:0] rdv;
  int ph = 0;
  int bad_count = 0;
  int num_checks = 0;

  // Short integration keeps the loop-up scenario brief
  rx_irq_mask_and_loop_code_regs #(.INTEGRATE(8)) u_rx_irq_mask_and_loop_code_regs (
    .sys_clk_i, .arst_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .elastic_timer_event_i(el_ev),
    .hdlc_event_i(hd_ev), .boc_fdl_event_i(bf_ev), .sa_six_codeword_i(sa6),
    .sa_bit_change_i(sa_ch), .sa_bit_position_mask_i(sa_msk), .sig_change_i(sig),
    .rx_bit_valid_i(bit_v), .rx_bit_i(bit_d), .rx_irq_source_summary_o(summ),
    .loop_up_seen_o(seen), .irq_request_o(irq));
  apb_host_model u_apb_host_model (
    .sys_clk_i, .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .hung_o(hung));

  initial forever #5 sys_clk_i = ~sys_clk_i;
  // Repeating 101 stream; idle bits toggle so nothing stale is seen
  always @(posedge sys_clk_i) begin
    bit_v <= stream_on;
    bit_d <= stream_on ? (ph != 1) : ~bit_d;
    ph <= (ph == 2) ? 0 : ph + 1;
  end
  always @(posedge hung) begin
    bad_count++;
    wrap_up();
  end

  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    u_apb_host_model.xfer(1'b1, ofs, d, rdv, err);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [15:0] exp);
    u_apb_host_model.xfer(1'b0, ofs, 8'h00, rdv, err);
    chk(rdv, exp);
  endtask
  task automatic fire(input int g, input logic [31:0] v);
    case (g)
      0: el_ev <= v[7:0];
      1: hd_ev <= v[5:0];
      2: bf_ev <= v[5:0];
      3: sa6 <= v[0];
      4: sa_ch <= v[7:0];
      default: sig <= v;
    endcase
    tick(1);
    el_ev <= 0;
    hd_ev <= 0;
    bf_ev <= 0;
    sa6 <= 0;
    sa_ch <= 0;
    sig <= 0;
    tick(3);
  endtask
  task automatic gate_bit(input int g, i, sb, sh, input logic [7:0] en, vld, clr);
    logic [7:0] m;
    m = 8'h01 << i;
    wr(en, m);
    fire(g, 32'(~m & vld));
    chk(16'(summ[sb] | irq), 16'h0000);
    rd(clr, 16'(~m & vld) << sh);
    fire(g, 32'(m));
    chk(16'(summ[sb] & irq), 16'h0001);
    rd(clr, 16'(m) << sh);
    tick(3);
    chk(16'(irq), 16'h0000);
  endtask

  task automatic t_regs;
    for (int a = 'ha3; a <= 'hae; a++) rd(8'(a), 16'h0000);
    chk(16'(err), 16'h0000);
    wr(8'ha5, 8'hff);
    rd(8'ha5, 16'h0000);
    chk(16'(err), 16'h0001);
    rd(CONTROL_OFS, 16'h000a);
  endtask
  task automatic t_groups;
    for (int i = 0; i < 8; i++)
      if (i != 4) gate_bit(0, i, 3, 0, ELASTIC_TIMER_EN_OFS, ELASTIC_TIMER_VALID, LATCHED_OFS);
    for (int i = 0; i < 6; i++) gate_bit(1, i, 4, 0, HDLC_EN_OFS, HDLC_VALID, STATUS_OFS);
    for (int i = 0; i < 6; i++) gate_bit(2, i, 6, 8, BOC_FDL_EN_OFS, BOC_FDL_T1_VALID, STATUS_OFS);
  endtask
  task automatic t_sig;
    wr(ELASTIC_TIMER_EN_OFS, 8'h08);
    wr(SIG_CH1_8_OFS, 8'h01);
    wr(SIG_CH25_32_OFS, 8'h80);
    fire(5, 32'h0000_0002);
    fire(5, 32'h8000_0000);
    chk(16'(summ[3]), 16'h0000);
    fire(5, 32'h0000_0001);
    chk(16'(summ[3]), 16'h0001);
    rd(LATCHED_OFS, 16'h0008);
    wr(CONTROL_OFS, 8'h0b);
    fire(5, 32'h8000_0000);
    rd(LATCHED_OFS, 16'h0008);
  endtask
  task automatic t_e1;
    wr(BOC_FDL_EN_OFS, 8'h01);
    fire(3, 32'h1);
    chk(16'(summ[6]), 16'h0000);
    rd(STATUS_OFS, 16'h0200);
    wr(BOC_FDL_EN_OFS, 8'h02);
    fire(3, 32'h1);
    chk(16'(summ[6]), 16'h0001);
    rd(STATUS_OFS, 16'h0200);
    wr(BOC_FDL_EN_OFS, 8'h01);
    sa_msk <= 8'h0f;
    fire(4, 32'h01);
    chk(16'(summ[6]), 16'h0000);
    fire(4, 32'h10);
    chk(16'(summ[6]), 16'h0001);
    rd(STATUS_OFS, 16'h0100);
  endtask
  task automatic t_loop;
    int n;
    wr(CONTROL_OFS, 8'h06);
    wr(LOOP_UP_HI_OFS, 8'h5a);
    stream_on <= 1;
    repeat (6) begin
      wr(LOOP_UP_LO_OFS, 8'had);
      chk(16'(seen), 16'h0000);
    end
    n = 0;
    while (seen !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(16'(seen), 16'h0001);
    if (seen !== 1'b1) wrap_up();
    tick(20);
    chk(16'(seen), 16'h0001);
    wr(LOOP_UP_LO_OFS, 8'h3f);
    tick(40);
    chk(16'(seen), 16'h0000);
    wr(CONTROL_OFS, 8'h07);
    wr(LOOP_UP_LO_OFS, 8'had);
    tick(40);
    chk(16'(seen), 16'h0000);
    stream_on <= 0;
  endtask

  initial begin
    tick(6);
    arst_n_i <= 1;
    tick(1);
    t_regs();
    t_groups();
    t_sig();
    t_e1();
    t_loop();
    wrap_up();
  end
endmodule
